// ===== core/pee_regs.svh
// constants and timing counts for the paged eeprom host controller
// Functional notes
// - host issues the three-write unlock sequence before the first byte of every page load.
// - host loads each page byte within the byte load window.
// - host keeps page address bits identical on every data-byte strobe fall of a load; the unlock writes use their own addresses.
// - true data after programming; host may poll anytime, write after true data. The host also returns to idle and takes writes after a poll timeout.
// - write mode is select low, output enable high, strobe low, data in.
`ifndef PEE_REGS_SVH
`define PEE_REGS_SVH
`define PEE_CLK_NS      10
`define PEE_TWP_NS      200
`define PEE_TWPH_NS     100
`define PEE_TACC_NS     200
`define PEE_BLC_US      150
`define PEE_TWC_MS      10
`define PEE_PWR_MS      5
`define PEE_SYNC_CYC    2
`define PEE_TWP_CYC     ((`PEE_TWP_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_TWPH_CYC    ((`PEE_TWPH_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_RD_CYC      (((`PEE_TACC_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS) + `PEE_SYNC_CYC)
`define PEE_BLC_CYC     ((`PEE_BLC_US * 1000) / `PEE_CLK_NS)
`define PEE_TWC_CYC     ((`PEE_TWC_MS * 1000000) / `PEE_CLK_NS)
`define PEE_PWR_CYC     ((`PEE_PWR_MS * 1000000 + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_BYTE_CYC    (1 + `PEE_TWP_CYC + `PEE_TWPH_CYC + 8)
`define PEE_UNLK_A0     17'h05555
`define PEE_UNLK_D0     8'haa
`define PEE_UNLK_A1     17'h02aaa
`define PEE_UNLK_D1     8'h55
`define PEE_UNLK_A2     17'h05555
`define PEE_UNLK_D2     8'ha0
`define PEE_PAGE_LSB    7
`define PEE_POLL_BIT    7
`endif

// ===== core/pee_pkg.sv
// types shared by the paged eeprom host controller
package pee_pkg;
  typedef enum logic [3:0] {
    PEE_IDLE    = 4'h0,
    PEE_SETUP   = 4'h1,
    PEE_STROBE  = 4'h3,
    PEE_RECOVER = 4'h2,
    PEE_LOADW   = 4'h6,
    PEE_READ    = 4'h7,
    PEE_GAP     = 4'h5
  } pee_state_t;
endpackage : pee_pkg

// ===== core/pee_sync.sv
// two-stage synchroniser for the data pins read back from the memory
`timescale 1ns/100ps
module pee_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pinIn,
  output      logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } pee_sync_t;

  pee_sync_t q;
  pee_sync_t next_q;

  // first stage feeds only the second stage
  always_comb begin
    next_q = q;
    for (int i = 0; i < WIDTH; i++) begin
      next_q.first[i]  = pinIn[i];
      next_q.second[i] = q.first[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign syncOut = q.second;
endmodule : pee_sync

// ===== core/pee_host.sv
// host controller that reads and page-writes a guarded parallel eeprom over its pins
`timescale 1ns/100ps
`include "pee_regs.svh"
module pee_host import pee_pkg::*; #(
  parameter logic [19:0] BLC_CYC   = 20'(`PEE_BLC_CYC),
  parameter logic [19:0] TWC_CYC   = 20'(`PEE_TWC_CYC),
  parameter logic [19:0] PWR_CYC   = 20'(`PEE_PWR_CYC),
  parameter logic [16:0] UNLK_A0   = `PEE_UNLK_A0,
  parameter logic [7:0]  UNLK_D0   = `PEE_UNLK_D0,
  parameter logic [16:0] UNLK_A1   = `PEE_UNLK_A1,
  parameter logic [7:0]  UNLK_D1   = `PEE_UNLK_D1,
  parameter logic [16:0] UNLK_A2   = `PEE_UNLK_A2,
  parameter logic [7:0]  UNLK_D2   = `PEE_UNLK_D2
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // user request
  input  wire logic        reqValid,
  output      logic        reqReady,
  input  wire logic        reqWrite,
  input  wire logic        reqLast,
  input  wire logic [16:0] reqAddr,
  input  wire logic [7:0]  reqData,
  // user response
  output      logic        rspValid,
  output      logic [7:0]  rspData,
  output      logic        rspTimeout,
  output      logic        writeAllowed,
  // memory pins
  output      logic        chipSel_b,
  output      logic        outEn_b,
  output      logic        writeStrobe_b,
  output      logic [16:0] byteAddressBits,
  output      logic [7:0]  dataPinsOut,
  output      logic        dataPinsOe_b,
  input  wire logic [7:0]  dataPinsIn
);
  localparam logic [7:0]  TWP_CYC  = 8'(`PEE_TWP_CYC);
  localparam logic [7:0]  TWPH_CYC = 8'(`PEE_TWPH_CYC);
  localparam logic [7:0]  RD_CYC   = 8'(`PEE_RD_CYC);
  localparam logic [19:0] BYTE_CYC = 20'(`PEE_BYTE_CYC);

  typedef struct packed {
    pee_state_t  state;
    logic [7:0]  cnt;
    logic [19:0] longCnt;
    logic [19:0] pwrCnt;
    logic        pwrOk;
    logic [1:0]  step;
    logic        finalByte;
    logic        isPoll;
    logic [9:0]  page;
    logic [16:0] lastAddr;
    logic [7:0]  lastData;
    logic [16:0] addr;
    logic [7:0]  dataOut;
    logic        ceN;
    logic        oeN;
    logic        weN;
    logic        dataOeN;
    logic        rspValid;
    logic [7:0]  rspData;
    logic        rspTimeout;
  } pee_host_t;

  pee_host_t  q;
  pee_host_t  next_q;
  logic [7:0] syncData;
  logic       pageMatch;
  logic       windowOk;

  pee_sync #(.WIDTH(8)) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinIn    (dataPinsIn),
    .syncOut  (syncData)
  );

  assign pageMatch = reqAddr[16:`PEE_PAGE_LSB] == q.page;
  assign windowOk  = (q.longCnt + BYTE_CYC) < BLC_CYC;
  // writes wait for the power-up delay; reads do not
  assign reqReady  = (q.state == PEE_IDLE && (!reqWrite || q.pwrOk)) ||
                     (q.state == PEE_LOADW && reqWrite && pageMatch && windowOk);

  always_comb begin
    next_q            = q;
    next_q.rspValid   = 1'b0;
    next_q.rspTimeout = 1'b0;
    if (!q.pwrOk) begin
      next_q.pwrCnt = q.pwrCnt + 20'h00001;
      next_q.pwrOk  = (q.pwrCnt + 20'h00001) >= PWR_CYC;
    end
    case (q.state)
      PEE_IDLE: begin
        if (reqValid && reqReady) begin
          next_q.lastAddr  = reqAddr;
          next_q.lastData  = reqData;
          next_q.finalByte = reqLast;
          next_q.page      = reqAddr[16:`PEE_PAGE_LSB];
          next_q.cnt       = 8'h00;
          if (reqWrite) begin
            // protection re-arms after every cycle, so each page opens with the unlock
            next_q.step    = 2'h0;
            next_q.addr    = UNLK_A0;
            next_q.dataOut = UNLK_D0;
            next_q.state   = PEE_SETUP;
          end else begin
            next_q.isPoll = 1'b0;
            next_q.addr   = reqAddr;
            next_q.state  = PEE_READ;
          end
        end
      end
      PEE_SETUP: begin
        next_q.cnt   = 8'h00;
        next_q.state = PEE_STROBE;
      end
      PEE_STROBE: begin
        // strobe held well past the glitch filter width
        next_q.cnt = q.cnt + 8'h01;
        if (q.cnt + 8'h01 >= TWP_CYC) begin
          next_q.cnt   = 8'h00;
          next_q.state = PEE_RECOVER;
        end
      end
      PEE_RECOVER: begin
        next_q.cnt = q.cnt + 8'h01;
        if (q.cnt + 8'h01 >= TWPH_CYC) begin
          next_q.cnt = 8'h00;
          if (q.step == 2'h0) begin
            next_q.step    = 2'h1;
            next_q.addr    = UNLK_A1;
            next_q.dataOut = UNLK_D1;
            next_q.state   = PEE_SETUP;
          end else if (q.step == 2'h1) begin
            next_q.step    = 2'h2;
            next_q.addr    = UNLK_A2;
            next_q.dataOut = UNLK_D2;
            next_q.state   = PEE_SETUP;
          end else if (q.step == 2'h2) begin
            next_q.step    = 2'h3;
            next_q.addr    = q.lastAddr;
            next_q.dataOut = q.lastData;
            next_q.state   = PEE_SETUP;
          end else begin
            next_q.longCnt = 20'h00000;
            next_q.state   = q.finalByte ? PEE_GAP : PEE_LOADW;
            next_q.isPoll  = 1'b1;
          end
        end
      end
      PEE_LOADW: begin
        next_q.longCnt = q.longCnt + 20'h00001;
        if (reqValid && reqReady) begin
          next_q.lastAddr  = reqAddr;
          next_q.lastData  = reqData;
          next_q.finalByte = reqLast;
          next_q.addr      = reqAddr;
          next_q.dataOut   = reqData;
          next_q.state     = PEE_SETUP;
        end else if (!windowOk || reqValid) begin
          // stop strobing; the device closes the load when its window runs out
          next_q.longCnt = 20'h00000;
          next_q.state   = PEE_GAP;
        end
      end
      PEE_READ: begin
        next_q.cnt = q.cnt + 8'h01;
        if (q.isPoll) begin
          next_q.longCnt = q.longCnt + 20'h00001;
        end
        if (q.cnt + 8'h01 >= RD_CYC) begin
          next_q.cnt   = 8'h00;
          next_q.state = PEE_GAP;
          if (!q.isPoll) begin
            next_q.rspValid = 1'b1;
            next_q.rspData  = syncData;
          end else if (syncData[`PEE_POLL_BIT] == q.lastData[`PEE_POLL_BIT]) begin
            // true data back on the polled bit: programming is over
            next_q.rspValid = 1'b1;
            next_q.rspData  = syncData;
            next_q.isPoll   = 1'b0;
          end else if (q.longCnt >= TWC_CYC + BLC_CYC) begin
            next_q.rspValid   = 1'b1;
            next_q.rspTimeout = 1'b1;
            next_q.rspData    = syncData;
            next_q.isPoll     = 1'b0;
          end
        end
      end
      PEE_GAP: begin
        next_q.cnt = q.cnt + 8'h01;
        if (q.isPoll) begin
          next_q.longCnt = q.longCnt + 20'h00001;
        end
        // outputs float and the bus settles between polls
        if (q.cnt + 8'h01 >= TWPH_CYC) begin
          next_q.cnt   = 8'h00;
          next_q.addr  = q.lastAddr;
          next_q.state = q.isPoll ? PEE_READ : PEE_IDLE;
        end
      end
      default: begin
        next_q.state = PEE_IDLE;
      end
    endcase
    // pin levels follow the state being entered
    next_q.ceN     = !(next_q.state inside {PEE_SETUP, PEE_STROBE, PEE_READ});
    next_q.weN     = next_q.state != PEE_STROBE;
    next_q.oeN     = next_q.state != PEE_READ;
    next_q.dataOeN = !(next_q.state inside {PEE_SETUP, PEE_STROBE, PEE_RECOVER});
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.state   <= PEE_IDLE;
      q.ceN     <= 1'b1;
      q.oeN     <= 1'b1;
      q.weN     <= 1'b1;
      q.dataOeN <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign chipSel_b       = q.ceN;
  assign outEn_b         = q.oeN;
  assign writeStrobe_b   = q.weN;
  assign byteAddressBits = q.addr;
  assign dataPinsOut     = q.dataOut;
  assign dataPinsOe_b    = q.dataOeN;
  assign rspValid        = q.rspValid;
  assign rspData         = q.rspData;
  assign rspTimeout      = q.rspTimeout;
  assign writeAllowed    = q.pwrOk;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  writeMode_a: assert property (!q.weN |-> q.oeN && !q.ceN && !q.dataOeN)
    else $error("strobe low outside write mode");
  readFloat_a: assert property (!q.oeN |-> q.dataOeN && q.weN)
    else $error("host drives data during read");
  strobeWidth_a: assert property ($fell(q.weN) |-> !q.weN [*8])
    else $error("write strobe pulse too short");
  pageSame_a: assert property ($fell(q.weN) && q.step == 2'h3 |-> q.addr[16:7] == q.page)
    else $error("page address changed in load");
  unlockAddr_a: assert property ($fell(q.weN) && q.step == 2'h0 |-> q.addr == UNLK_A0 && q.dataOut == UNLK_D0)
    else $error("unlock sequence address wrong");
  powerDelay_a: assert property (!q.weN |-> q.pwrOk)
    else $error("write before power-up delay");
  loadWindow_a: assert property (q.state == PEE_LOADW |-> q.longCnt < BLC_CYC)
    else $error("byte load window overrun");
  pinsStable_a: assert property (!q.weN && $past(!q.weN) |-> $stable(q.addr) && $stable(q.dataOut))
    else $error("address or data moved under strobe");
  pollBound_a: assert property (q.isPoll && q.state == PEE_READ |-> q.longCnt <= TWC_CYC + BLC_CYC + 20'h00100)
    else $error("polling past cycle time bound");

  pageDone_c: cover property (q.rspValid && !q.rspTimeout && q.step == 2'h3);
  userRead_c: cover property (q.rspValid && q.step != 2'h3);
  multiByte_c: cover property (q.state == PEE_LOADW ##1 q.state == PEE_SETUP);
  timeout_c: cover property (q.rspTimeout);
endmodule : pee_host

// ===== bench/pee_mem_model.sv
// behavioural paged eeprom device model answering the host pins
`timescale 1ns/100ps
`include "pee_regs.svh"
module pee_mem_model #(
  parameter int PWR  = 20,
  parameter int BLC  = 400,
  parameter int PROG = 300,
  parameter int ACC  = 12
) (
  // sampling clock
  input  wire logic        core_clk,
  // memory pins
  input  wire logic        chipSel_b,
  input  wire logic        outEn_b,
  input  wire logic        writeStrobe_b,
  input  wire logic [16:0] addrPins,
  input  wire logic [7:0]  hostData,
  input  wire logic        hostOe_b,
  output      logic [7:0]  wirePins,
  // host protocol faults seen
  output      logic [7:0]  badWrites
);
  logic [7:0]   mem [0:131071];
  logic [7:0]   pbuf [0:127];
  logic [127:0] pmask;
  logic [16:0]  latA;
  logic [16:0]  lastA;
  logic [16:0]  pageA;
  logic [7:0]   lastD;
  logic [7:0]   v;
  logic         loading;
  logic         tog;
  int           upCnt;
  int           actCnt;
  int           winCnt;
  int           busyCnt;
  int           rdCnt;
  int           step;

  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
    pmask = '0;
    loading = 1'b0;
    tog = 1'b0;
    badWrites = 8'h00;
    wirePins = 8'h00;
    lastA = '0;
    lastD = 8'h00;
    {upCnt, actCnt, winCnt, busyCnt, rdCnt, step} = '0;
  end

  // command values are parameters of the build, not fixed in silicon
  function automatic logic isCmd(int s, logic [16:0] a, logic [7:0] d);
    return (s == 0 && a == `PEE_UNLK_A0 && d == `PEE_UNLK_D0) || (s == 1 && a == `PEE_UNLK_A1 &&
      d == `PEE_UNLK_D1) || (s == 2 && a == `PEE_UNLK_A2 && d == `PEE_UNLK_D2);
  endfunction : isCmd

  task automatic accept(logic [16:0] a, logic [7:0] d);
    lastA = a;
    lastD = d;
    if (!loading && step == 3) begin
      loading = 1'b1;
      pageA = a;
      step = 0;
    end
    if (loading) begin
      if (a[16:7] != pageA[16:7]) badWrites++;
      pbuf[a[6:0]] = d;
      pmask[a[6:0]] = 1'b1;
      winCnt = 0;
    end else if (isCmd(step, a, d)) step++;
    else begin
      busyCnt = PROG;
      step = 0;
      badWrites++;
    end
  endtask : accept

  // pins sampled on the falling edge, where the host's registered outputs are settled
  always @(negedge core_clk) begin
    if (upCnt < PWR) upCnt++;
    if (!writeStrobe_b && !outEn_b) badWrites++;
    if (!chipSel_b && outEn_b && !writeStrobe_b) begin
      if (actCnt == 0) latA = addrPins;
      actCnt++;
    end else begin
      if (actCnt >= 2 && upCnt >= PWR && busyCnt == 0) accept(latA, hostData);
      actCnt = 0;
    end
    if (loading && ++winCnt >= BLC) begin
      loading = 1'b0;
      busyCnt = PROG;
    end
    if (busyCnt > 0 && --busyCnt == 0) begin
      for (int i = 0; i < 128; i++) if (pmask[i]) mem[{pageA[16:7], 7'(i)}] = pbuf[i];
      pmask = '0;
    end
    if (!chipSel_b && !outEn_b && writeStrobe_b) begin
      if (rdCnt == 0 && busyCnt > 0) tog = ~tog;
      rdCnt++;
    end else rdCnt = 0;
    v = mem[addrPins];
    if (busyCnt > 0) begin
      v[6] = tog;
      if (addrPins == lastA) v[7] = ~lastD[7];
    end
    if (!hostOe_b) begin
      wirePins <= hostData;
      if (rdCnt > 0) badWrites++;
    end else if (rdCnt > ACC) wirePins <= v;
    else wirePins <= ~wirePins;
  end
endmodule : pee_mem_model

// ===== bench/tb_paged_eeprom_access_logic.sv
// self-checking bench for the paged eeprom host controller
`timescale 1ns/100ps
module tb_paged_eeprom_access_logic import pee_pkg::*;;
  logic        core_clk;
  logic        rst_b;
  logic        reqValid;
  logic        reqReady;
  logic        reqWrite;
  logic        reqLast;
  logic [16:0] reqAddr;
  logic [7:0]  reqData;
  logic        rspValid;
  logic [7:0]  rspData;
  logic        rspTimeout;
  logic        writeAllowed;
  logic        chipSel_b;
  logic        outEn_b;
  logic        writeStrobe_b;
  logic [16:0] byteAddressBits;
  logic [7:0]  dataPinsOut;
  logic        dataPinsOe_b;
  logic [7:0]  dataPinsIn;
  logic [7:0]  badWrites;
  logic [7:0]  rData;
  logic        rTo;
  int          mismatches;
  int          totalChecks;

  pee_host #(.BLC_CYC(20'd400), .TWC_CYC(20'd500), .PWR_CYC(20'd20)) dut_u (.core_clk(core_clk),
    .rst_b(rst_b), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqLast(reqLast),
    .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .rspTimeout(rspTimeout),
    .writeAllowed(writeAllowed), .chipSel_b(chipSel_b), .outEn_b(outEn_b), .writeStrobe_b(writeStrobe_b),
    .byteAddressBits(byteAddressBits), .dataPinsOut(dataPinsOut), .dataPinsOe_b(dataPinsOe_b),
    .dataPinsIn(dataPinsIn));

  // model defaults already match the shortened window and power-up counts given above; its programming time of 300 is below the cycle count of 500
  pee_mem_model mem_u (.core_clk(core_clk),
    .chipSel_b(chipSel_b), .outEn_b(outEn_b), .writeStrobe_b(writeStrobe_b), .addrPins(byteAddressBits),
    .hostData(dataPinsOut), .hostOe_b(dataPinsOe_b), .wirePins(dataPinsIn), .badWrites(badWrites));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic stall(string what);
    mismatches++;
    $display("CHECK FAILED %s expected handshake seen none", what);
    conclude();
  endtask : stall

  task automatic send(logic w, logic last, logic [16:0] a, logic [7:0] d);
    int n;
    @(negedge core_clk);
    reqValid = 1'b1;
    reqWrite = w;
    reqLast = last;
    reqAddr = a;
    reqData = d;
    #1;
    for (n = 0; n < 2000 && reqReady !== 1'b1; n++) begin
      @(negedge core_clk);
      #1;
    end
    if (n == 2000) stall("request taken");
    @(posedge core_clk);
  endtask : send

  task automatic getRsp();
    int n;
    @(negedge core_clk);
    reqValid = 1'b0;
    for (n = 0; n < 5000; n++) begin
      @(posedge core_clk);
      #1;
      if (rspValid === 1'b1) break;
    end
    if (n == 5000) stall("response");
    rData = rspData;
    rTo = rspTimeout;
  endtask : getRsp

  task automatic readChk(logic [16:0] a, logic [7:0] exp, string what);
    send(1'b0, 1'b0, a, 8'h00);
    getRsp();
    check(what, rData, exp);
  endtask : readChk

  task automatic testReset();
    int n;
    check("select idle", {chipSel_b, writeStrobe_b, outEn_b}, 3'b111);
    check("data drive idle", dataPinsOe_b, 1'b1);
    check("write allowed at reset", writeAllowed, 1'b0);
    for (n = 0; n < 100 && writeAllowed !== 1'b1; n++) @(negedge core_clk);
    if (n == 100) stall("write allowed");
    check("power-up wait", n >= 18 && n <= 22, 1'b1);
    readChk(17'h1abcd, 8'hff, "erased byte");
    $display("test reset done");
  endtask : testReset

  task automatic testPage();
    send(1'b1, 1'b0, 17'h00105, 8'h3c);
    send(1'b1, 1'b0, 17'h00100, 8'ha5);
    send(1'b1, 1'b1, 17'h00105, 8'h77);
    getRsp();
    check("page timeout flag", rTo, 1'b0);
    check("page poll data", rData, 8'h77);
    readChk(17'h00105, 8'h77, "reloaded byte");
    readChk(17'h00100, 8'ha5, "first byte");
    readChk(17'h00101, 8'hff, "unloaded byte");
    readChk(17'h05555, 8'hff, "command address");
    $display("test page done");
  endtask : testPage

  task automatic testFull();
    for (int i = 0; i < 128; i++) send(1'b1, i == 127, {10'h158, 7'(i)}, 8'(i) ^ 8'h5a);
    getRsp();
    check("full page poll", {rTo, rData}, 9'h025);
    for (int i = 0; i < 128; i++) readChk({10'h158, 7'(i)}, 8'(i) ^ 8'h5a, "full page byte");
    readChk(17'h0ab7f, 8'hff, "page below");
    $display("test full page done");
  endtask : testFull

  task automatic testWindow();
    send(1'b1, 1'b0, 17'h02aaa, 8'h3c);
    getRsp();
    check("window poll", {rTo, rData}, 9'h03c);
    readChk(17'h02aaa, 8'h3c, "command address data");
    readChk(17'h02aab, 8'hff, "window neighbour");
    // a read offered during the load cuts it; the read is served only once programming is over
    send(1'b1, 1'b0, 17'h00300, 8'h12);
    readChk(17'h00300, 8'h12, "read after cut load");
    check("device faults", badWrites, 8'h00);
    $display("test window done");
  endtask : testWindow

  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqLast = 1'b0;
    reqAddr = 17'h00000;
    reqData = 8'h00;
    mismatches = 0;
    totalChecks = 0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    testReset();
    testPage();
    testFull();
    testWindow();
    conclude();
  end
endmodule : tb_paged_eeprom_access_logic
